// ==== core/bsd_pkg.sv ====
package bsd_pkg;

    // First opcode bytes.
    localparam logic [7:0] OP_REG_GROUP  = 8'h7a;
    localparam logic [7:0] OP_REG_REG    = 8'h8a;
    localparam logic [7:0] OP_PREFIX_EXT = 8'h3c;
    localparam logic [7:0] OP_AREA_AREA  = 8'h2a;

    // Second byte of the extended and area-to-area forms.
    localparam logic [7:0] B2_EXT_REG    = 8'h8a;
    localparam logic [7:0] B2_AREA2_AREA2 = 8'h0a;
    localparam logic [7:0] B2_AREA1_AREA1 = 8'h3a;

    // Low-nibble selectors of the register group.
    localparam logic [3:0] NIB_REG_AREA2 = 4'h0;
    localparam logic [3:0] NIB_REG_AREA1 = 4'h1;
    localparam logic [3:0] NIB_REG_SFR   = 4'h2;
    localparam logic [3:0] NIB_REG_IMM   = 4'h3;
    localparam logic [3:0] NIB_AREA2_REG = 4'h4;
    localparam logic [3:0] NIB_AREA1_REG = 4'h5;
    localparam logic [3:0] NIB_SFR_REG   = 4'h6;

    // Field positions inside a register byte.
    localparam int DEST_MSB = 7;
    localparam int DEST_LSB = 4;
    localparam int ZERO_BIT = 3;
    localparam int SRC_MSB  = 2;

    // Operand kinds presented to execute.
    typedef enum logic [3:0] {
        KIND_NONE  = 4'h0,
        KIND_REG   = 4'h1,
        KIND_IMM   = 4'h2,
        KIND_AREA1 = 4'h3,
        KIND_AREA2 = 4'h4,
        KIND_SFR   = 4'h5
    } bsd_kind_type;

endpackage : bsd_pkg

// ==== core/bsd_field_reg.sv ====
`timescale 1ns/1ps
`default_nettype none

// Loadable byte register with clear.
module bsd_field_reg #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    input  wire logic             clear_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic      [WIDTH-1:0] data_o
);

    // Single register; clear wins over load.
    always_ff @(posedge clock_i)
    begin
        if (srst_i || clear_i)
            data_o <= '0;
        else if (load_i)
            data_o <= data_i;
    end

endmodule : bsd_field_reg

`default_nettype wire

// ==== core/bsd_decoder.sv ====
// Operation
// RQ1 - First byte 7a and second low nibble 3 decodes register minus immediate, immediate in byte three.
// RQ2 - First byte 7a and low nibble 0 decodes register minus area two, offset in byte three.
// RQ3 - First byte 7a and low nibble 1 decodes register minus area one, offset in byte three.
// RQ4 - First byte 7a and low nibble 4 makes area two the destination and the register the source.
// RQ5 - First byte 7a and low nibble 5 makes area one the destination and the register the source.
// RQ6 - First byte 7a and low nibble 2 decodes register minus special register, offset in byte three.
// RQ7 - First byte 7a and low nibble 6 makes the special register the destination.
// RQ8 - First byte 8a starts a two-byte register subtract with dest nibble, zero bit, source field.
// RQ9 - Prefix 3c then 8a starts the extended register subtract with the register byte third.
// RQ10 - Bytes 2a then 0a subtract area two from area two, source offset third, destination fourth.
// RQ11 - Bytes 2a then 3a subtract area one from area one, source offset third, destination fourth.
// RQ12 - Any other byte sequence is flagged undefined and issues no subtract.
`timescale 1ns/1ps
`default_nettype none

module bsd_decoder (
    input  wire logic               clock_i,
    input  wire logic               srst_i,
    input  wire logic               byte_valid_i,
    input  wire logic [7:0]         byte_i,
    output logic                    byte_ready_o,
    output logic                    issue_valid_o,
    input  wire logic               issue_ready_i,
    output logic                    undefined_o,
    output bsd_pkg::bsd_kind_type   dest_kind_o,
    output bsd_pkg::bsd_kind_type   src_kind_o,
    output logic [3:0]              dest_reg_field_o,
    output logic [2:0]              src_reg_field_o,
    output logic [7:0]              dest_offset_o,
    output logic [7:0]              src_offset_o,
    output logic [7:0]              imm_o
);

    ////////////////////////////////////////////////////////////////////////
    // State types.

    typedef enum logic [6:0] {
        ST_B1    = 7'h01,
        ST_B2    = 7'h02,
        ST_B3    = 7'h04,
        ST_B4    = 7'h08,
        ST_ISSUE = 7'h10,
        ST_UNDEF = 7'h20,
        ST_EXT   = 7'h40
    } bsd_state_type;

    typedef struct packed {
        bsd_state_type         state;
        logic [7:0]            first;
        bsd_pkg::bsd_kind_type dkind;
        bsd_pkg::bsd_kind_type skind;
        logic [3:0]            dreg;
        logic [2:0]            sreg;
    } bsd_regs_type;

    bsd_regs_type r_q;
    bsd_regs_type r_d;

    // Byte capture strobes for the offset and immediate fields.
    logic       take;
    logic       ld_doff;
    logic       ld_soff;
    logic       ld_imm;
    logic       clr;
    logic [3:0] nib;

    assign take = byte_valid_i && byte_ready_o;
    assign nib  = byte_i[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Next-state and field decode.

    always_comb
    begin
        r_d     = r_q;
        ld_doff = 1'b0;
        ld_soff = 1'b0;
        ld_imm  = 1'b0;
        clr     = 1'b0;
        case (r_q.state)
            ST_B1:
            begin
                if (take)
                begin
                    r_d.first = byte_i;
                    r_d.dkind = bsd_pkg::KIND_NONE;
                    r_d.skind = bsd_pkg::KIND_NONE;
                    r_d.dreg  = 4'h0;
                    r_d.sreg  = 3'h0;
                    clr       = 1'b1;
                    if (byte_i == bsd_pkg::OP_REG_GROUP
                        || byte_i == bsd_pkg::OP_REG_REG
                        || byte_i == bsd_pkg::OP_PREFIX_EXT
                        || byte_i == bsd_pkg::OP_AREA_AREA)
                        r_d.state = ST_B2;
                    else
                        // RQ12 unknown first byte
                        r_d.state = ST_UNDEF;
                end
            end
            ST_B2:
            begin
                if (take)
                begin
                    r_d.state = ST_UNDEF;
                    if (r_q.first == bsd_pkg::OP_REG_GROUP)
                    begin
                        r_d.dreg  = byte_i[bsd_pkg::DEST_MSB:bsd_pkg::DEST_LSB];
                        r_d.sreg  = 3'h0;
                        r_d.state = ST_B3;
                        case (nib)
                            // RQ1 register minus immediate
                            bsd_pkg::NIB_REG_IMM:
                            begin
                                r_d.dkind = bsd_pkg::KIND_REG;
                                r_d.skind = bsd_pkg::KIND_IMM;
                            end
                            // RQ2 register minus area two
                            bsd_pkg::NIB_REG_AREA2:
                            begin
                                r_d.dkind = bsd_pkg::KIND_REG;
                                r_d.skind = bsd_pkg::KIND_AREA2;
                            end
                            // RQ3 register minus area one
                            bsd_pkg::NIB_REG_AREA1:
                            begin
                                r_d.dkind = bsd_pkg::KIND_REG;
                                r_d.skind = bsd_pkg::KIND_AREA1;
                            end
                            // RQ4 area two destination
                            bsd_pkg::NIB_AREA2_REG:
                            begin
                                r_d.dkind = bsd_pkg::KIND_AREA2;
                                r_d.skind = bsd_pkg::KIND_REG;
                            end
                            // RQ5 area one destination
                            bsd_pkg::NIB_AREA1_REG:
                            begin
                                r_d.dkind = bsd_pkg::KIND_AREA1;
                                r_d.skind = bsd_pkg::KIND_REG;
                            end
                            // RQ6 register minus special register
                            bsd_pkg::NIB_REG_SFR:
                            begin
                                r_d.dkind = bsd_pkg::KIND_REG;
                                r_d.skind = bsd_pkg::KIND_SFR;
                            end
                            // RQ7 special register destination
                            bsd_pkg::NIB_SFR_REG:
                            begin
                                r_d.dkind = bsd_pkg::KIND_SFR;
                                r_d.skind = bsd_pkg::KIND_REG;
                            end
                            default:
                                // RQ12 unknown selector nibble
                                r_d.state = ST_UNDEF;
                        endcase
                    end
                    else if (r_q.first == bsd_pkg::OP_REG_REG)
                    begin
                        // RQ8 two-byte register form
                        if (!byte_i[bsd_pkg::ZERO_BIT])
                        begin
                            r_d.dreg  = byte_i[bsd_pkg::DEST_MSB:
                                               bsd_pkg::DEST_LSB];
                            r_d.sreg  = byte_i[bsd_pkg::SRC_MSB:0];
                            r_d.dkind = bsd_pkg::KIND_REG;
                            r_d.skind = bsd_pkg::KIND_REG;
                            r_d.state = ST_ISSUE;
                        end
                    end
                    else if (r_q.first == bsd_pkg::OP_PREFIX_EXT)
                    begin
                        // RQ9 extended register prefix
                        if (byte_i == bsd_pkg::B2_EXT_REG)
                            r_d.state = ST_EXT;
                    end
                    else
                    begin
                        // RQ10 area two pair
                        if (byte_i == bsd_pkg::B2_AREA2_AREA2)
                        begin
                            r_d.dkind = bsd_pkg::KIND_AREA2;
                            r_d.skind = bsd_pkg::KIND_AREA2;
                            r_d.state = ST_B3;
                        end
                        // RQ11 area one pair
                        else if (byte_i == bsd_pkg::B2_AREA1_AREA1)
                        begin
                            r_d.dkind = bsd_pkg::KIND_AREA1;
                            r_d.skind = bsd_pkg::KIND_AREA1;
                            r_d.state = ST_B3;
                        end
                    end
                end
            end
            ST_EXT:
            begin
                if (take)
                begin
                    // RQ9 extended register byte
                    if (!byte_i[bsd_pkg::ZERO_BIT])
                    begin
                        r_d.dreg  = byte_i[bsd_pkg::DEST_MSB:bsd_pkg::DEST_LSB];
                        r_d.sreg  = byte_i[bsd_pkg::SRC_MSB:0];
                        r_d.dkind = bsd_pkg::KIND_REG;
                        r_d.skind = bsd_pkg::KIND_REG;
                        r_d.state = ST_ISSUE;
                    end
                    else
                        r_d.state = ST_UNDEF;
                end
            end
            ST_B3:
            begin
                if (take)
                begin
                    if (r_q.first == bsd_pkg::OP_AREA_AREA)
                    begin
                        // RQ10 source offset third
                        ld_soff   = 1'b1;
                        r_d.state = ST_B4;
                    end
                    else
                    begin
                        r_d.state = ST_ISSUE;
                        if (r_q.skind == bsd_pkg::KIND_IMM)
                            // RQ1 immediate byte
                            ld_imm = 1'b1;
                        else if (r_q.skind == bsd_pkg::KIND_REG)
                            // RQ4 offset names destination
                            ld_doff = 1'b1;
                        else
                            // RQ2 offset names source
                            ld_soff = 1'b1;
                    end
                end
            end
            ST_B4:
            begin
                if (take)
                begin
                    // RQ11 destination offset fourth
                    ld_doff   = 1'b1;
                    r_d.state = ST_ISSUE;
                end
            end
            ST_ISSUE, ST_UNDEF:
            begin
                if (issue_ready_i)
                    r_d.state = ST_B1;
            end
            default:
                r_d.state = ST_B1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            r_q <= '{state: ST_B1, first: 8'h00,
                     dkind: bsd_pkg::KIND_NONE,
                     skind: bsd_pkg::KIND_NONE,
                     dreg: 4'h0, sreg: 3'h0};
        else
            r_q <= r_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte fields.

    bsd_field_reg #(.WIDTH(8)) u_doff (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .clear_i (clr),
        .load_i  (ld_doff),
        .data_i  (byte_i),
        .data_o  (dest_offset_o)
    );

    bsd_field_reg #(.WIDTH(8)) u_soff (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .clear_i (clr),
        .load_i  (ld_soff),
        .data_i  (byte_i),
        .data_o  (src_offset_o)
    );

    bsd_field_reg #(.WIDTH(8)) u_imm (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .clear_i (clr),
        .load_i  (ld_imm),
        .data_i  (byte_i),
        .data_o  (imm_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs; bytes are accepted in every state except while a result or the undefined flag is pending.

    assign byte_ready_o     = (r_q.state == ST_B1) || (r_q.state == ST_B2)
                              || (r_q.state == ST_B3) || (r_q.state == ST_B4)
                              || (r_q.state == ST_EXT);
    assign issue_valid_o    = (r_q.state == ST_ISSUE);
    // RQ12 undefined flag
    assign undefined_o      = (r_q.state == ST_UNDEF);
    assign dest_kind_o      = r_q.dkind;
    assign src_kind_o       = r_q.skind;
    assign dest_reg_field_o = r_q.dreg;
    assign src_reg_field_o  = r_q.sreg;

endmodule : bsd_decoder

`default_nettype wire

// ==== test/bsd_decoder_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module bsd_decoder_sva (
    input wire logic                  clock_i,
    input wire logic                  srst_i,
    input wire logic                  byte_valid_i,
    input wire logic [7:0]            byte_i,
    input wire logic                  byte_ready_o,
    input wire logic                  issue_valid_o,
    input wire logic                  issue_ready_i,
    input wire logic                  undefined_o,
    input wire logic [3:0]            dest_kind_o,
    input wire logic [3:0]            src_kind_o,
    input wire logic [3:0]            dest_reg_field_o,
    input wire logic [2:0]            src_reg_field_o,
    input wire logic [7:0]            dest_offset_o,
    input wire logic [7:0]            src_offset_o,
    input wire logic [7:0]            imm_o
);
    logic       take;
    logic       done;
    logic [1:0] pos_q;
    logic [7:0] first_q;
    logic [7:0] second_q;
    logic [7:0] last_q;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    // Byte accepted and result acknowledged.
    assign take = byte_valid_i && byte_ready_o;
    assign done = (issue_valid_o || undefined_o) && issue_ready_i;

    ////////////////////////////////////////////////////////////////////////
    // Tracks the byte position and the bytes seen inside an instruction.
    always_ff @(posedge clock_i)
    begin
        if (srst_i || done)
            pos_q <= 2'h0;
        else if (take)
            pos_q <= pos_q + 2'h1;
        if (take && pos_q == 2'h0)
            first_q <= byte_i;
        if (take && pos_q == 2'h1)
            second_q <= byte_i;
        if (take)
            last_q <= byte_i;
    end

    ////////////////////////////////////////////////////////////////////////
    chk_busy_blocks: assert property (
        (issue_valid_o || undefined_o) |-> !byte_ready_o)
        else $error("Byte accepted while a result is pending.");
    chk_result_holds: assert property (
        issue_valid_o && !issue_ready_i |=> issue_valid_o
        && $stable(dest_kind_o) && $stable(src_offset_o)
        && $stable(dest_offset_o) && $stable(imm_o))
        else $error("Result changed before it was taken.");
    chk_ack_clears: assert property (
        done |=> !issue_valid_o && !undefined_o)
        else $error("Result stayed after acknowledge.");
    chk_not_both: assert property (
        !(issue_valid_o && undefined_o))
        else $error("Issue and undefined raised together.");
    chk_bad_first: assert property (
        take && pos_q == 2'h0
        && !(byte_i inside {8'h7a, 8'h8a, 8'h3c, 8'h2a}) |=> undefined_o)
        else $error("Unknown first byte not flagged.");
    chk_short_reg: assert property (
        take && pos_q == 2'h1 && first_q == 8'h8a && !byte_i[3]
        |=> issue_valid_o && dest_reg_field_o == last_q[7:4]
        && src_reg_field_o == last_q[2:0])
        else $error("Register pair form decoded wrongly.");
    chk_long_reg: assert property (
        take && pos_q == 2'h2 && first_q == 8'h3c && second_q == 8'h8a
        && !byte_i[3] |=> issue_valid_o
        && dest_reg_field_o == last_q[7:4]
        && src_reg_field_o == last_q[2:0])
        else $error("Prefixed register form decoded wrongly.");
    chk_imm_field: assert property (
        take && pos_q == 2'h2 && first_q == 8'h7a && second_q[3:0] == 4'h3
        |=> issue_valid_o && src_kind_o == bsd_pkg::KIND_IMM
        && imm_o == last_q)
        else $error("Immediate form decoded wrongly.");
    chk_area_dest: assert property (
        take && pos_q == 2'h3 && first_q == 8'h2a && second_q == 8'h0a
        |=> issue_valid_o && dest_kind_o == bsd_pkg::KIND_AREA2
        && dest_offset_o == last_q)
        else $error("Area two destination decoded wrongly.");
    chk_sfr_src: assert property (
        take && pos_q == 2'h2 && first_q == 8'h7a && second_q[3:0] == 4'h2
        |=> src_kind_o == bsd_pkg::KIND_SFR && src_offset_o == last_q)
        else $error("Special register source decoded wrongly.");

    // Main scenarios reached.
    cov_four_bytes: cover property (take && pos_q == 2'h3);
    cov_undefined: cover property (undefined_o && issue_ready_i);
    cov_stall: cover property (issue_valid_o && !issue_ready_i);

endmodule : bsd_decoder_sva

bind bsd_decoder bsd_decoder_sva u_sva (
    .clock_i(clock_i), .srst_i(srst_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .byte_ready_o(byte_ready_o),
    .issue_valid_o(issue_valid_o), .issue_ready_i(issue_ready_i),
    .undefined_o(undefined_o), .dest_kind_o(dest_kind_o),
    .src_kind_o(src_kind_o), .dest_reg_field_o(dest_reg_field_o),
    .src_reg_field_o(src_reg_field_o), .dest_offset_o(dest_offset_o),
    .src_offset_o(src_offset_o), .imm_o(imm_o));

`default_nettype wire

// ==== test/bsd_fetch_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module bsd_fetch_model (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       byte_ready_i,
    output logic            byte_valid_o,
    output logic [7:0]      byte_o
);
    logic [7:0] q [$];
    int         taken = 0;

    // Queues one opcode byte for delivery.
    task automatic push(input logic [7:0] value);
        q.push_back(value);
    endtask : push

    initial
    begin
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
    end

    // Offers bytes with random stalls; an idle line shows the inverse.
    always @(posedge clock_i)
    begin
        if (byte_valid_o && byte_ready_i && !srst_i)
            taken++;
        if (srst_i)
            byte_valid_o <= 1'b0;
        else if (!byte_valid_o || byte_ready_i)
        begin
            if (q.size() != 0 && $urandom_range(0, 3) != 0)
            begin
                byte_valid_o <= 1'b1;
                byte_o <= q.pop_front();
            end
            else
            begin
                byte_valid_o <= 1'b0;
                byte_o <= ~byte_o;
            end
        end
    end

endmodule : bsd_fetch_model

`default_nettype wire

// ==== test/tb_byte_subtract_opcode_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_byte_subtract_opcode_decoder;
    logic                  clock_i = 1'b0;
    logic                  srst_i = 1'b1;
    logic                  issue_ready_i = 1'b0;
    logic                  byte_valid_i;
    logic [7:0]            byte_i;
    logic                  byte_ready_o;
    logic                  issue_valid_o;
    logic                  undefined_o;
    bsd_pkg::bsd_kind_type dest_kind_o;
    bsd_pkg::bsd_kind_type src_kind_o;
    logic [3:0]            dest_reg_field_o;
    logic [2:0]            src_reg_field_o;
    logic [7:0]            dest_offset_o;
    logic [7:0]            src_offset_o;
    logic [7:0]            imm_o;
    int                    mismatches = 0;
    int                    check_count = 0;
    logic [7:0]            b [4];
    int                    ek, sk, dr, sr, dof, sof, imm, und, len;
    int                    ekt [7] = '{1, 1, 1, 1, 4, 3, 5};
    int                    skt [7] = '{4, 3, 5, 2, 1, 1, 1};

    always #10 clock_i = ~clock_i;

    bsd_fetch_model fetch (.clock_i(clock_i), .srst_i(srst_i),
        .byte_ready_i(byte_ready_o), .byte_valid_o(byte_valid_i),
        .byte_o(byte_i));

    bsd_decoder dut (.clock_i(clock_i), .srst_i(srst_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i),
        .byte_ready_o(byte_ready_o), .issue_valid_o(issue_valid_o),
        .issue_ready_i(issue_ready_i), .undefined_o(undefined_o),
        .dest_kind_o(dest_kind_o), .src_kind_o(src_kind_o),
        .dest_reg_field_o(dest_reg_field_o),
        .src_reg_field_o(src_reg_field_o), .dest_offset_o(dest_offset_o),
        .src_offset_o(src_offset_o), .imm_o(imm_o));

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // Compares one seen value with its expectation.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Expected fields of a register byte.
    task automatic reg_byte(input logic [7:0] r);
        if (r[3])
            und = 1;
        else
        begin
            ek = 1;
            sk = 1;
            dr = r[7:4];
            sr = r[2:0];
        end
    endtask : reg_byte

    // Reference decode of the bytes in b.
    task automatic expect_fields();
        logic [3:0] nib;
        nib = b[1][3:0];
        {ek, sk, dof, sof, imm, und} = '0;
        dr = -1;
        sr = -1;
        len = 2;
        case (b[0])
            8'h7a:
                if (nib > 4'h6)
                    und = 1;
                else
                begin
                    len = 3;
                    ek = ekt[nib];
                    sk = skt[nib];
                    if (nib < 4'h3)
                        sof = b[2];
                    else if (nib == 4'h3)
                        imm = b[2];
                    else
                        dof = b[2];
                    dr = b[1][7:4];
                end
            8'h8a: reg_byte(b[1]);
            8'h3c:
                if (b[1] != 8'h8a)
                    und = 1;
                else
                begin
                    len = 3;
                    reg_byte(b[2]);
                end
            8'h2a:
                if (b[1] == 8'h0a || b[1] == 8'h3a)
                begin
                    len = 4;
                    ek = (b[1] == 8'h0a) ? 4 : 3;
                    sk = ek;
                    sof = b[2];
                    dof = b[3];
                end
                else
                    und = 1;
            default:
            begin
                und = 1;
                len = 1;
            end
        endcase
    endtask : expect_fields

    // Sends one sequence, waits for the answer, compares and acknowledges.
    task automatic run_one();
        int n;
        int t0;
        n = 0;
        t0 = fetch.taken;
        expect_fields();
        for (int i = 0; i < len; i++)
            fetch.push(b[i]);
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (issue_valid_o !== 1'b1 && undefined_o !== 1'b1 && n < 60);
        if (n >= 60)
        begin
            mismatches++;
            end_sim();
        end
        repeat ($urandom_range(0, 2)) @(posedge clock_i);
        check({6'h0, issue_valid_o, undefined_o}, und ? 8'h01 : 8'h02);
        if (!und)
        begin
            check(dest_kind_o, ek);
            check(src_kind_o, sk);
            check(dest_offset_o, dof);
            check(src_offset_o, sof);
            check(imm_o, imm);
            if (dr >= 0)
                check(dest_reg_field_o, dr);
            if (sr >= 0)
                check(src_reg_field_o, sr);
        end
        check(fetch.taken - t0, len);
        issue_ready_i <= 1'b1;
        @(posedge clock_i);
        issue_ready_i <= 1'b0;
    endtask : run_one

    ////////////////////////////////////////////////////////////////////////
    // Random mix of every form, stalls on both sides, bad codes included.
    initial
    begin
        void'($urandom(31));
        repeat (12) @(posedge clock_i);
        srst_i <= 1'b0;
        for (int t = 0; t < 400; t++)
        begin
            foreach (b[i])
                b[i] = 8'($urandom);
            case ($urandom_range(0, 5))
                0, 1: b[0] = 8'h7a;
                2: b[0] = 8'h8a;
                3: b[0] = 8'h3c;
                4: b[0] = 8'h2a;
                default: ;
            endcase
            if (b[0] == 8'h3c && $urandom_range(0, 3) != 0)
                b[1] = 8'h8a;
            if (b[0] == 8'h2a && $urandom_range(0, 3) != 0)
                b[1] = $urandom_range(0, 1) ? 8'h0a : 8'h3a;
            run_one();
        end
        end_sim();
    end

endmodule : tb_byte_subtract_opcode_decoder

`default_nettype wire
